// >>> core/wwdt_pkg.sv
// Shared constants for the windowed watchdog timer
package wwdt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] OPT_IDX  = 16'h0080; // Option byte copy
    localparam logic [15:0] REF_IDX  = 16'hFF9B; // Refresh key register
    localparam logic [15:0] STAT_IDX = 16'h0100; // Counter status
    localparam int          IDX_LSB  = 2;        // Word address lsb
    // Refresh key and read-back values
    localparam logic [7:0]  KEY_VAL     = 8'hAC; // Service key
    localparam logic [7:0]  REF_RST_ON  = 8'h9A; // Read value, enabled
    localparam logic [7:0]  REF_RST_OFF = 8'h1A; // Read value, disabled
    // Option byte fields
    localparam int          OPT_LOCK_POS = 0;     // Oscillator lock
    localparam int          OPT_OVF_LSB  = 1;     // Overflow select, 3 bits
    localparam int          OPT_EN_POS   = 4;     // Counter enable
    localparam int          OPT_WIN_LSB  = 5;     // Open period, 2 bits
    localparam logic [7:0]  OPT_RST      = 8'h00; // Before strap capture
    // Counter sizing
    localparam int          OVF_BASE_EXP = 10;    // Code 000 = 2^10
    localparam int          CNT_W_DEF    = 17;    // Holds up to 2^17
    // Status word fields
    localparam int          STAT_OPEN_POS  = 24;  // Window open
    localparam int          STAT_FIRST_POS = 25;  // First write seen
    localparam int          STAT_PEND_POS  = 26;  // Reset deferred
    // Reset cause bit set for the reset controller
    localparam int          CAUSE_BIT = 4;
    // Data areas exempt from the access check
    localparam logic [15:0] EXC0_LO = 16'hFB00;
    localparam logic [15:0] EXC0_HI = 16'hFFCF;
    localparam logic [15:0] EXC1_LO = 16'hFFE0;
endpackage : wwdt_pkg

// >>> core/wwdt_tick_if.sv
// Tick and run status passed from the oscillator stage to the core
`timescale 1ns/10ps
`default_nettype none
interface wwdt_tick_if;
    logic tick; // One-cycle pulse per low-speed period
    logic run;  // Low-speed source running
    logic lock; // Oscillator lock option
    modport src (output tick, output run, input lock);
    modport snk (input tick, input run, output lock);
endinterface : wwdt_tick_if
`default_nettype wire

// >>> core/wwdt_tick.sv
// Low-speed oscillator edge detector and run qualifier
`timescale 1ns/10ps
`default_nettype none
module wwdt_tick
    import wwdt_pkg::*;
(
    input  wire logic   clk_i,      // System clock
    input  wire logic   rst_i,      // Synchronous reset
    input  wire logic   lsosc_i,    // Low-speed oscillator level
    input  wire logic   halt_i,     // CPU in HALT
    input  wire logic   stop_i,     // CPU in STOP
    input  wire logic   osc_stop_i, // Software oscillator stop bit
    wwdt_tick_if.src    tk          // Tick towards the core
);
    // All state of this stage
    typedef struct packed {
        logic prev; // Last oscillator level
        logic tick; // Rising edge seen
        logic run;  // Source running
    } wwdt_tk_s;

    wwdt_tk_s q; // Registered state
    wwdt_tk_s d; // Next state

    // Without the lock the source halts in low-power modes
    always_comb
    begin
        d      = q;
        d.prev = lsosc_i;
        d.run  = tk.lock | ~(halt_i | stop_i | osc_stop_i);
        d.tick = lsosc_i & ~q.prev & d.run;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '{prev: 1'b0, tick: 1'b0, run: 1'b1};
        else
            q <= d;
    end

    assign tk.tick = q.tick;
    assign tk.run  = q.run;
endmodule : wwdt_tick
`default_nettype wire

// >>> core/wwdt_top.sv
// Windowed watchdog timer core with AHB-Lite register slave
//
// Summary of operation
// - Count on low-speed oscillator ticks only
// - Overflow without refresh raises internal reset
// - Bit-manipulation access to refresh register resets
// - Any non-key refresh value raises reset
// - Key write clears counter and restarts
// - Write in closed window resets, even key
// - Fetch outside memory areas resets when enabled
// - Data access outside areas resets, exempt ranges
// - Watchdog reset sets cause bit four
// - Refresh register resets to 9A or 1A
// - Refresh read returns reset value only
// - Enable option gates counting and access checks
// - Three-bit code picks 2^10..2^17 ticks
// - Two-bit code picks final open fraction
// - First write after reset ignores window
// - Refresh errors wait for running source clock
// - Key clear may shift overflow two ticks
// - Refresh at last count still clears
// - Without lock, pause in HALT and STOP
// - Without lock, oscillator stop holds count
`timescale 1ns/10ps
`default_nettype none
module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF // Counter width
)
(
    input  wire logic        clk_i,          // 100 MHz clock
    input  wire logic        rst_i,          // Synchronous reset
    input  wire logic        hsel_i,         // AHB select
    input  wire logic [31:0] haddr_i,        // AHB address
    input  wire logic [1:0]  htrans_i,       // AHB transfer type
    input  wire logic        hwrite_i,       // AHB write
    input  wire logic [2:0]  hsize_i,        // AHB size
    input  wire logic [31:0] hwdata_i,       // AHB write data
    input  wire logic        hready_i,       // AHB ready in
    output logic      [31:0] hrdata_o,       // AHB read data
    output logic             hreadyout_o,    // AHB ready out
    output logic             hresp_o,        // AHB response
    input  wire logic [7:0]  option_byte_i,  // Option byte strap
    input  wire logic        bitmanip_i,     // Access is 1-bit op
    input  wire logic        lsosc_i,        // Low-speed oscillator
    input  wire logic        halt_i,         // HALT mode
    input  wire logic        stop_i,         // STOP mode
    input  wire logic        osc_stop_i,     // Oscillator stop bit
    input  wire logic        fetch_i,        // Instruction fetch
    input  wire logic        fetch_in_map_i, // Fetch inside areas
    input  wire logic        data_acc_i,     // CPU data access
    input  wire logic [15:0] data_addr_i,    // Data access address
    input  wire logic        data_in_map_i,  // Data inside areas
    output logic             wdt_rst_req_o,  // Reset request pulse
    output logic      [7:0]  cause_set_o     // Cause bits to set
);
    // Refuse widths that cannot hold 2^17 or fit the status word
    if (CNT_W < 17 || CNT_W > STAT_OPEN_POS)
        $error("wwdt_top: CNT_W must be 17 to 24");

    // All state of the core
    typedef struct packed {
        logic [CNT_W-1:0] cnt;        // Watchdog count
        logic [7:0]       opt;        // Captured option byte
        logic             opt_vld;    // Option captured
        logic             first_done; // First refresh seen
        logic             pend;       // Deferred refresh error
        logic             rst_req;    // Reset request pulse
        logic [7:0]       cause;      // Cause bits pulse
        logic             wr_ref;     // Refresh write data phase
        logic             bitop;      // That write was a 1-bit op
        logic             rdy;        // Ready out
        logic [31:0]      hrdata;     // Read data
    } wwdt_st_s;

    localparam wwdt_st_s RST_VAL = '{
        cnt: '0, opt: OPT_RST, opt_vld: 1'b0, first_done: 1'b0,
        pend: 1'b0, rst_req: 1'b0, cause: 8'h00, wr_ref: 1'b0,
        bitop: 1'b0, rdy: 1'b1, hrdata: 32'h0000_0000};

    wwdt_st_s q; // Registered state
    wwdt_st_s d; // Next state

    wwdt_tick_if tk (); // Tick link to oscillator stage

    logic [CNT_W:0]   lim;       // Overflow length in ticks
    logic [CNT_W:0]   last;      // Final count before overflow
    logic [CNT_W:0]   close_len; // Closed window length
    logic [2:0]       ovf_sel;   // Overflow code
    logic [1:0]       win_sel;   // Open period code
    logic             en;        // Counting and checks enabled
    logic             win_open;  // Window currently open
    logic             acc;       // AHB address phase taken
    logic [15:0]      idx;       // Register index
    logic             ref_bad;   // Refresh write is an error
    logic             ref_good;  // Valid refresh
    logic             ovf;       // Overflow this cycle
    logic             illegal;   // Illegal fetch or data access
    logic             exempt;    // Data address in exempt range
    logic             fire;      // Raise reset now

    // Oscillator stage; lock option steers its run qualifier
    wwdt_tick u_tick (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .lsosc_i    (lsosc_i),
        .halt_i     (halt_i),
        .stop_i     (stop_i),
        .osc_stop_i (osc_stop_i),
        .tk         (tk.src)
    );
    assign tk.lock = q.opt[OPT_LOCK_POS];

    // Option decode
    assign en      = q.opt_vld & q.opt[OPT_EN_POS];
    assign ovf_sel = q.opt[OPT_OVF_LSB +: 3];
    assign win_sel = q.opt[OPT_WIN_LSB +: 2];
    assign lim     = {{CNT_W{1'b0}}, 1'b1}
                     << (OVF_BASE_EXP + int'(ovf_sel));
    assign last    = lim - {{CNT_W{1'b0}}, 1'b1};

    // Closed part is the front of the overflow time
    always_comb
    begin
        case (win_sel)
            2'b00:   close_len = lim - (lim >> 2);
            2'b01:   close_len = lim >> 1;
            2'b10:   close_len = lim >> 2;
            2'b11:   close_len = '0;
            default: close_len = '0;
        endcase
    end
    assign win_open = {1'b0, q.cnt} >= close_len;

    // Bus decode; zero wait states so every taken phase is serviced
    assign acc = hsel_i & htrans_i[1] & hready_i;
    assign idx = haddr_i[IDX_LSB +: 16];

    // Refresh data phase check
    assign ref_bad = q.wr_ref & en & (q.bitop
                     | (hwdata_i[7:0] != KEY_VAL)
                     | (q.first_done & ~win_open));
    assign ref_good = q.wr_ref & en & ~ref_bad;
    // A valid refresh on the final tick wins over the overflow
    assign ovf = en & tk.run & tk.tick & ~ref_good
                 & (q.cnt == last[CNT_W-1:0]);

    // Data areas outside the maps but exempt from checking
    assign exempt  = (data_addr_i >= EXC0_LO && data_addr_i <= EXC0_HI)
                     || (data_addr_i >= EXC1_LO);
    assign illegal = en & ((fetch_i & ~fetch_in_map_i)
                     | (data_acc_i & ~data_in_map_i & ~exempt));
    // A refresh error with the source stopped waits in pend
    assign fire = ovf | illegal | ((ref_bad | q.pend) & tk.run);

    // Next-state logic
    always_comb
    begin
        d         = q;
        d.rst_req = 1'b0;
        d.cause   = 8'h00;
        d.wr_ref  = 1'b0;
        d.bitop   = 1'b0;
        d.rdy     = 1'b1;
        // Strap caught once, the cycle after reset release
        if (!q.opt_vld)
        begin
            d.opt     = option_byte_i;
            d.opt_vld = 1'b1;
        end
        // Address phase: read data prepared for the data phase
        if (acc && !hwrite_i)
        begin
            case (idx)
                OPT_IDX:  d.hrdata = {24'h000000, q.opt};
                REF_IDX:  d.hrdata = {24'h000000,
                              q.opt[OPT_EN_POS] ? REF_RST_ON
                                                : REF_RST_OFF};
                STAT_IDX:
                begin
                    d.hrdata = 32'h0000_0000;
                    d.hrdata[CNT_W-1:0]     = q.cnt;
                    d.hrdata[STAT_OPEN_POS]  = win_open;
                    d.hrdata[STAT_FIRST_POS] = q.first_done;
                    d.hrdata[STAT_PEND_POS]  = q.pend;
                end
                default:  d.hrdata = 32'h0000_0000; // Unmapped
            endcase
        end
        // Address phase: refresh write remembered for its data
        if (acc && hwrite_i && idx == REF_IDX)
        begin
            d.wr_ref = 1'b1;
            d.bitop  = bitmanip_i;
        end
        // Counting, halted when the source is not running
        if (en && tk.run && tk.tick)
            d.cnt = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        // A refresh overrides the increment, even at the last count;
        // the clear lands within one tick, inside the allowed slack
        if (ref_good)
        begin
            d.cnt        = '0;
            d.first_done = 1'b1;
        end
        if (ref_bad && !tk.run)
            d.pend = 1'b1;
        // One request with its cause bits to the reset controller
        if (fire)
        begin
            d.rst_req         = 1'b1;
            d.cause[CAUSE_BIT] = 1'b1;
            d.cnt             = '0;
            d.first_done      = 1'b0;
            d.pend            = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= RST_VAL;
        else
            q <= d;
    end

    // Outputs straight from the state register
    assign hrdata_o      = q.hrdata;
    assign hreadyout_o   = q.rdy;
    assign hresp_o       = q.cause[0]; // Cause bit 0 never set: OKAY
    assign wdt_rst_req_o = q.rst_req;
    assign cause_set_o   = q.cause;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    key_clear_a: assert property (ref_good && !fire |=> q.cnt == '0)
        else $error("valid key did not clear the counter");
    bad_key_a: assert property (
        q.wr_ref && en && tk.run && hwdata_i[7:0] != KEY_VAL
        |=> wdt_rst_req_o && cause_set_o[CAUSE_BIT])
        else $error("bad key did not raise reset");
    bit_op_a: assert property (
        q.wr_ref && q.bitop && en && tk.run |=> wdt_rst_req_o)
        else $error("bit operation did not raise reset");
    overflow_rst_a: assert property (
        en && tk.run && tk.tick && q.cnt == last[CNT_W-1:0] && !ref_good
        |=> wdt_rst_req_o ##1 !wdt_rst_req_o)
        else $error("overflow reset missing or not a pulse");
    closed_win_a: assert property (
        q.wr_ref && en && tk.run && q.first_done && !win_open
        |=> wdt_rst_req_o)
        else $error("write in closed window did not reset");
    last_refresh_a: assert property (
        ref_good && tk.run && tk.tick && q.cnt == last[CNT_W-1:0]
        && !illegal |=> !wdt_rst_req_o && q.cnt == '0)
        else $error("refresh at last count did not clear");
    pause_hold_a: assert property (
        en && !tk.run && !fire |=> q.cnt == $past(q.cnt))
        else $error("counter moved while source stopped");
    defer_rst_a: assert property (
        q.pend && !tk.run |=> !wdt_rst_req_o)
        else $error("deferred reset issued early");
    cause_pair_a: assert property (
        wdt_rst_req_o |-> cause_set_o == 8'h10)
        else $error("reset without cause bit");
    ref_read_a: assert property (
        acc && !hwrite_i && idx == REF_IDX
        |=> hrdata_o[7:0] == REF_RST_ON || hrdata_o[7:0] == REF_RST_OFF)
        else $error("refresh read returned wrong value");
    disabled_a: assert property (
        q.opt_vld && !q.opt[OPT_EN_POS] |=> !wdt_rst_req_o && q.cnt == '0)
        else $error("disabled watchdog acted");

    refresh_c: cover property (ref_good ##1 q.first_done);
    overflow_c: cover property (ovf ##1 wdt_rst_req_o);
    window_c: cover property (q.wr_ref && q.first_done && win_open);
    defer_c: cover property (q.pend ##[1:50] wdt_rst_req_o);
endmodule : wwdt_top
`default_nettype wire

// >>> sim/wwdt_cpu_model.sv
// CPU bus master model issuing single AHB-Lite word transfers
`timescale 1ns/10ps
`default_nettype none
module wwdt_cpu_model (
    input  wire logic        clk_i,     // System clock
    input  wire logic        hready_i,  // Bus ready
    input  wire logic [31:0] hrdata_i,  // Read data
    output var  logic        hsel_o,    // Select
    output var  logic [31:0] haddr_o,   // Byte address
    output var  logic [1:0]  htrans_o,  // Transfer type
    output var  logic        hwrite_o,  // Write
    output var  logic [2:0]  hsize_o,   // Always a word
    output var  logic [31:0] hwdata_o,  // Write data
    output var  logic        bitmanip_o // Marks a 1-bit op
);
    // Idle bus from time zero
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
        bitmanip_o = 1'b0;
    end
    // One transfer, entered just after a rising edge; waits on ready
    // rather than assuming zero wait states
    task automatic xfer(input logic wr, input logic bm,
                        input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'b1;
        haddr_o <= a;
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        bitmanip_o <= bm;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        bitmanip_o <= 1'b0;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask : xfer
endmodule : wwdt_cpu_model
`default_nettype wire

// >>> sim/windowed_watchdog_timer_tb_top.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_tb_top
    import wwdt_pkg::*;
;
    localparam logic [31:0] REF_A = {14'h0, REF_IDX, 2'h0}; // Key addr
    // Access table: bit 16 set where a reset is expected
    localparam logic [16:0] DTAB [7] = '{17'h0FB00, 17'h0FFCF,
        17'h0FFE0, 17'h0FFFF, 17'h1FAFF, 17'h1FFD0, 17'h1FFDF};
    logic        clk_i;                // System clock
    logic        rst_i = 1'b1;         // Reset, asserted at start
    logic        lsosc_i = 1'b0;       // Low-speed oscillator
    logic [7:0]  option_byte_i = 8'h0; // Option strap
    logic [2:0]  pause = 3'h0;         // Halt, stop, osc stop
    logic [3:0]  acc = 4'h0;           // Fetch, in map, data, in map
    logic [15:0] daddr = 16'h0;        // Data access address
    logic        hsel, hwrite, bm, hready, hresp, rreq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [7:0]  cause;
    int          seed = 32'h77cc;      // Fixed random seed
    int          pulses = 0;           // Reset requests seen
    int          cycles = 0;           // Timeout counter
    int          miscompares = 0;
    int          n_tests = 0;

    wwdt_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp),
        .option_byte_i(option_byte_i), .bitmanip_i(bm),
        .lsosc_i(lsosc_i), .halt_i(pause[0]), .stop_i(pause[1]),
        .osc_stop_i(pause[2]), .fetch_i(acc[0]),
        .fetch_in_map_i(acc[1]), .data_acc_i(acc[2]),
        .data_addr_i(daddr), .data_in_map_i(acc[3]),
        .wdt_rst_req_o(rreq), .cause_set_o(cause));
    wwdt_cpu_model cpu (
        .clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
        .bitmanip_o(bm));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Oscillator stands still while software stops it
    always @(posedge clk_i)
        if (!pause[2])
            lsosc_i <= ~lsosc_i;
    // Count requests; the cause bits must ride along with each one
    always @(posedge clk_i)
        if (rreq === 1'b1)
        begin
            pulses <= pulses + 1;
            check({24'h0, cause}, 32'h10);
        end
    // Hang guard, about half again the expected run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    function automatic logic [7:0] opt(input logic en, input logic [2:0] ov,
                                       input logic [1:0] w, input logic lk);
        return {1'b0, w, en, ov, lk};
    endfunction : opt
    // Option is only taken at the first edge after release
    task automatic boot(input logic [7:0] o);
        rst_i <= 1'b1;
        option_byte_i <= o;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : boot
    task automatic wr(input logic [7:0] k, input logic b);
        cpu.xfer(1'b1, b, REF_A, {24'h0, k}, rdat);
    endtask : wr
    task automatic rd_ref(input logic [7:0] e);
        cpu.xfer(1'b0, 1'b0, REF_A, 32'h0, rdat);
        check(rdat, {24'h0, e});
    endtask : rd_ref
    task automatic pulses_after(input int w, input int e);
        int p;
        p = pulses;
        repeat (w) @(posedge clk_i);
        check(32'(pulses - p), 32'(e));
    endtask : pulses_after
    // Tolerance covers tick sync and the two-tick clear slack
    task automatic wait_pulse(input int e);
        int p;
        int n;
        p = pulses;
        n = 0;
        while (pulses == p)
        begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n >= e - 8 && n <= e + 8), 32'h1);
    endtask : wait_pulse
    task automatic acc_pulse(input logic [3:0] a, input logic [15:0] ad,
                             input int e);
        acc <= a;
        daddr <= ad;
        @(posedge clk_i);
        acc <= 4'h0;
        pulses_after(3, e);
    endtask : acc_pulse

    initial
    begin
        logic [7:0] k;
        int cl;
        // Overflow length per code, two clocks per tick
        for (int c = 0; c < 3; c++)
        begin
            boot(opt(1'b1, 3'(c), 2'h3, 1'b1));
            wait_pulse(2 << (10 + c));
        end
        $display("test overflow done");
        // Window fractions at code 001
        for (int w = 0; w < 4; w++)
        begin
            cl = 512 * (3 - w);
            boot(opt(1'b1, 3'h1, 2'(w), 1'b0));
            rd_ref(REF_RST_ON);
            wr(KEY_VAL, 1'b0);
            pulses_after(3, 0);
            rd_ref(REF_RST_ON);
            if (cl > 0)
            begin
                repeat (2 * cl - 60) @(posedge clk_i);
                wr(KEY_VAL, 1'b0);
                pulses_after(3, 1);
                wr(KEY_VAL, 1'b0);
            end
            repeat (2 * cl + 60) @(posedge clk_i);
            wr(KEY_VAL, 1'b0);
            pulses_after(3, 0);
            wait_pulse(4093);
        end
        $display("test window done");
        // Refresh errors and illegal accesses
        boot(opt(1'b1, 3'h3, 2'h3, 1'b0));
        k = 8'($random(seed));
        if (k == KEY_VAL)
            k = 8'h00;
        wr(k, 1'b0);
        pulses_after(3, 1);
        wr(KEY_VAL, 1'b1);
        pulses_after(3, 1);
        acc_pulse(4'h1, 16'h0, 1);
        acc_pulse(4'h3, 16'h0, 0);
        for (int i = 0; i < 7; i++)
            acc_pulse(4'h4, DTAB[i][15:0], int'(DTAB[i][16]));
        acc_pulse(4'h4, 16'($random(seed)) & 16'hFAFF, 1);
        acc_pulse(4'hC, 16'($random(seed)), 0);
        $display("test errors done");
        // Halt, stop and oscillator stop hold the count without lock
        for (int m = 0; m < 3; m++)
        begin
            boot(opt(1'b1, 3'h0, 2'h3, 1'b0));
            repeat (1000) @(posedge clk_i);
            pause[m] <= 1'b1;
            pulses_after(3000, 0);
            pause[m] <= 1'b0;
            wait_pulse(1048);
        end
        boot(opt(1'b1, 3'h0, 2'h3, 1'b1));
        pause <= 3'h3;
        wait_pulse(2048);
        pause <= 3'h0;
        // Bad key while the source clock is stopped
        boot(opt(1'b1, 3'h3, 2'h3, 1'b0));
        pause <= 3'h4;
        wr(KEY_VAL ^ 8'h01, 1'b0);
        pulses_after(20, 0);
        pause <= 3'h0;
        pulses_after(6, 1);
        $display("test pause done");
        // Disabled watchdog ignores everything
        boot(opt(1'b0, 3'h0, 2'h3, 1'b0));
        rd_ref(REF_RST_OFF);
        cpu.xfer(1'b0, 1'b0, 32'h800, 32'h0, rdat);
        check(rdat, 32'h0);
        check({30'h0, hready, hresp}, 32'h2);
        wr(8'h55, 1'b0);
        acc_pulse(4'h1, 16'h0, 0);
        pulses_after(3000, 0);
        $display("test disabled done");
        results();
    end
endmodule : windowed_watchdog_timer_tb_top
`default_nettype wire
